/* File: ict_pkg.sv */
// Shared constants and types of the I2C control, status and time-out block
package ict_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_DATA = 8'hbc;
  localparam logic [7:0] IDX_STATE = 8'hbd;
  localparam logic [7:0] IDX_RATE = 8'hbe;
  localparam logic [7:0] IDX_TOC = 8'hbf;
  localparam logic [7:0] IDX_CTRL = 8'hc0;
  localparam logic [7:0] IDX_OWN = 8'hc1;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // Values after reset
  localparam logic [7:0] RST_RATE = 8'h09;

  // Field positions
  localparam int CTRL_EN = 6;
  localparam int CTRL_STA = 5;
  localparam int CTRL_STO = 4;
  localparam int CTRL_SI = 3;
  localparam int CTRL_AA = 2;
  localparam int CTRL_PX = 0;
  localparam int TOC_EN = 2;
  localparam int TOC_DIV = 1;
  localparam int TOC_FLAG = 0;
  localparam int OWN_LSB = 1;

  // Counts
  localparam int TMO_W = 14;
  localparam logic [1:0] TMO_PRE_LAST = 2'h3;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Status codes
  localparam logic [7:0] ST_BUS_ERR = 8'h00;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_TX_ACK = 8'h28;
  localparam logic [7:0] ST_TX_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_AR_ACK = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_RX_ACK = 8'h50;
  localparam logic [7:0] ST_RX_NACK = 8'h58;
  localparam logic [7:0] ST_SW_ADDR = 8'h60;
  localparam logic [7:0] ST_SRX_ACK = 8'h80;
  localparam logic [7:0] ST_SRX_NACK = 8'h88;
  localparam logic [7:0] ST_SSTOP = 8'ha0;
  localparam logic [7:0] ST_SR_ADDR = 8'ha8;
  localparam logic [7:0] ST_STX_ACK = 8'hb8;
  localparam logic [7:0] ST_STX_NACK = 8'hc0;
  localparam logic [7:0] ST_STX_LAST = 8'hc8;
  localparam logic [7:0] ST_IDLE = 8'hf8;

  typedef struct packed {
    logic lvl;
    logic rise;
    logic fall;
  } ict_line_s;

  typedef enum logic [2:0] {S_IDLE, S_MSTART, S_MBIT, S_MSTOP, S_SBIT, S_HOLD} ict_state_e;

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    ict_state_e st;
    logic [4:0] stat;
    logic si;
    logic start_request;
    logic stop_request;
    logic aa;
    logic en;
    logic px;
    logic [7:0] rate;
    logic toen;
    logic todiv;
    logic tof;
    logic [7:0] data;
    logic [6:0] own;
    logic mst;
    logic rd;
    logic addr_ph;
    logic moved;
    logic busy;
    logic addressed;
    logic ackd;
    logic scl_lo;
    logic sda_lo;
    logic [3:0] bitcnt;
    logic [1:0] ph;
    logic [7:0] tick;
  } ict_core_s;

  localparam ict_core_s CORE_RST = '{st: S_IDLE, stat: ST_IDLE[7:3], rate: RST_RATE,
                                     default: '0};
endpackage

/* File: ict_sync.sv */
// Two-stage line synchroniser with edge detection
`timescale 1ns/1ns
module ict_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic pin_in,
  output ict_pkg::ict_line_s line_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ict_sync_s;

  ict_sync_s q;
  ict_sync_s n;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = q;
    n.s1 = pin_in;
    n.s2 = q.s1;
    n.s3 = q.s2;
  end

  // Idle bus is high, so reset to high avoids a false edge
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      q <= '1;
    else if (ce_in)
      q <= n;
  end

  assign line_out.lvl = q.s2;
  assign line_out.rise = q.s2 & ~q.s3;
  assign line_out.fall = ~q.s2 & q.s3;
endmodule

/* File: ict_tmo.sv */
// Bus time-out counter with divide-by-four prescaler
`timescale 1ns/1ns
module ict_tmo #(
  parameter int WIDTH = ict_pkg::TMO_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic en_in,
  input wire logic div4_in,
  input wire logic clr_in,
  output logic ovf_out
);
  typedef struct packed {
    logic [1:0] pre;
    logic [WIDTH-1:0] cnt;
    logic ovf;
  } ict_tmo_s;

  ict_tmo_s q;
  ict_tmo_s n;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = q;
    n.ovf = 1'b0;
    if (!en_in || clr_in)
    begin
      n.pre = '0;
      n.cnt = '0;
    end
    else
    begin
      n.pre = q.pre + 2'h1;
      if (!div4_in || q.pre == ict_pkg::TMO_PRE_LAST)
      begin
        n.cnt = q.cnt + 1'b1;
        n.ovf = &q.cnt;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      q <= '0;
    else if (ce_in)
      q <= n;
  end

  assign ovf_out = q.ovf;
endmodule

/* File: ict_ctrl.sv */
// I2C controller: Wishbone registers, master and slave engine, time-out
// Summary of operation
// - Status register upper five bits hold one of twenty-seven state codes; this block defines twenty-one.
// - Idle code F8 means nothing to report; service flag stays clear; reset value.
// - Entering any other state sets the service flag and requests service.
// - Status register low three bits always read zero.
// - Master bus clock is system clock over four times divider plus one; this block takes five times divider plus one.
// - Slave mode ignores divider and follows the master's clock.
// - Enabled 14-bit time-out counter overflow sets sticky flag, software clears.
// - Prescale bit picks counter clock: system clock, or divided by four.
// - Start request on free bus issues START; busy bus waits for STOP first.
// - Start request as master after a byte gives a repeated START.
// - Stop request in master mode sends STOP; cleared when STOP seen on bus.
// - Stop request in bus-error state recovers without driving STOP.
// - Start and stop together as master give STOP then START.
// - Service flag set holds clock low; only software clears it, then resume. Bus error, lost arbitration and slave STOP leave it released.
// - After flag clear, next action follows control bits set beforehand.
// - Acknowledge enable drives ACK low as receiver or addressed slave, else NACK.
// - Data register is not changed by hardware while service flag is set.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns
module ict_ctrl #(
  parameter int ADR_W = 12
) (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [ADR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE_OUT,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT
);
  ict_pkg::ict_core_s q;
  ict_pkg::ict_core_s n;
  ict_pkg::ict_line_s scl;
  ict_pkg::ict_line_s sda;
  logic tmo_ovf;
  logic [7:0] idx;
  logic [7:0] wd;
  logic hit;
  logic req;
  logic wr;
  logic hw_si;
  logic qtick;
  logic start_det;
  logic stop_det;
  logic tx;
  logic [7:0] rd_val;

  function automatic logic [4:0] sc(input logic [7:0] code);
    return code[7:3];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  ict_sync u_scl_sync (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .pin_in(SCL_IN),
    .line_out(scl)
  );

  ict_sync u_sda_sync (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .pin_in(SDA_IN),
    .line_out(sda)
  );

  // Runs only while a transfer is under way; any clock edge restarts it
  ict_tmo #(
    .WIDTH(ict_pkg::TMO_W)
  ) u_tmo (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .en_in(q.toen & q.en & (q.st != ict_pkg::S_IDLE)),
    .div4_in(q.todiv),
    .clr_in(scl.rise | scl.fall),
    .ovf_out(tmo_ovf)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = q;
    hw_si = 1'b0;
    qtick = 1'b0;
    idx = WB_ADR_IN[ict_pkg::IDX_MSB:ict_pkg::IDX_LSB];
    wd = WB_DAT_IN[7:0];
    hit = (WB_ADR_IN[ADR_W-1:ict_pkg::IDX_MSB+1] == '0) &&
          (idx >= ict_pkg::IDX_DATA) && (idx <= ict_pkg::IDX_OWN);
    req = WB_CYC_IN & WB_STB_IN;
    wr = req & WB_WE_IN & q.ack & WB_SEL_IN[0] & hit;
    start_det = scl.lvl & sda.fall;
    stop_det = scl.lvl & sda.rise;
    tx = q.addr_ph | ~q.rd;
    case (idx)
      ict_pkg::IDX_DATA: rd_val = q.data;
      ict_pkg::IDX_STATE: rd_val = {q.stat, 3'h0};
      ict_pkg::IDX_RATE: rd_val = q.rate;
      ict_pkg::IDX_TOC: rd_val = {5'h00, q.toen, q.todiv, q.tof};
      ict_pkg::IDX_CTRL: rd_val = {1'b0, q.en, q.start_request, q.stop_request, q.si, q.aa, 1'b0, q.px};
      ict_pkg::IDX_OWN: rd_val = {q.own, 1'b0};
      default: rd_val = 8'h00;
    endcase

    // Bus slave: answer one cycle after the request, unmapped reads give zero
    n.ack = req & ~q.ack;
    if (req & ~q.ack)
      n.rdat = hit ? rd_val : 8'h00;

    // Bus line watch
    if (start_det)
      n.busy = 1'b1;
    if (stop_det)
    begin
      n.busy = 1'b0;
      n.stop_request = 1'b0;
    end

    if (wr)
    begin
      case (idx)
        ict_pkg::IDX_DATA: n.data = wd;
        ict_pkg::IDX_RATE: n.rate = wd;
        ict_pkg::IDX_TOC:
        begin
          n.toen = wd[ict_pkg::TOC_EN];
          n.todiv = wd[ict_pkg::TOC_DIV];
        end
        ict_pkg::IDX_CTRL:
        begin
          n.en = wd[ict_pkg::CTRL_EN];
          n.start_request = wd[ict_pkg::CTRL_STA];
          n.stop_request = wd[ict_pkg::CTRL_STO];
          n.aa = wd[ict_pkg::CTRL_AA];
          n.px = wd[ict_pkg::CTRL_PX];
        end
        ict_pkg::IDX_OWN: n.own = wd[7:ict_pkg::OWN_LSB];
        default: n.own = q.own;
      endcase
    end

    // Quarter-bit tick: rate+1 cycles, five per bit as the clock release is seen a tick late
    if (q.tick >= q.rate)
    begin
      n.tick = 8'h00;
      qtick = 1'b1;
    end
    else
      n.tick = q.tick + 8'h01;

    ////////////////////////////////////////////////////////////////////////
    case (q.st)
      ict_pkg::S_IDLE:
      begin
        n.scl_lo = 1'b0;
        n.sda_lo = 1'b0;
        n.mst = 1'b0;
        n.addressed = 1'b0;
        if (q.en && q.start_request && !q.busy)
        begin
          n.st = ict_pkg::S_MSTART;
          n.ph = 2'h0;
          n.moved = 1'b0;
        end
        else if (q.en && q.aa && start_det)
        begin
          n.st = ict_pkg::S_SBIT;
          n.bitcnt = 4'h0;
          n.addr_ph = 1'b1;
        end
      end
      ict_pkg::S_MSTART:
      begin
        if (qtick)
        begin
          case (q.ph)
            2'h0:
            begin
              n.sda_lo = 1'b0;
              n.ph = 2'h1;
            end
            2'h1:
            begin
              n.scl_lo = 1'b0;
              if (scl.lvl && sda.lvl)
                n.ph = 2'h2;
            end
            2'h2:
            begin
              n.sda_lo = 1'b1;
              n.ph = 2'h3;
            end
            default:
            begin
              n.scl_lo = 1'b1;
              n.stat = q.moved ? sc(ict_pkg::ST_RSTART) : sc(ict_pkg::ST_START);
              hw_si = 1'b1;
              n.mst = 1'b1;
              n.addr_ph = 1'b1;
              n.moved = 1'b0;
              n.st = ict_pkg::S_HOLD;
            end
          endcase
        end
      end
      ict_pkg::S_MBIT:
      begin
        if (start_det || stop_det)
        begin
          // A condition in mid-byte that this end did not make
          n.stat = sc(ict_pkg::ST_BUS_ERR);
          hw_si = 1'b1;
          n.mst = 1'b0;
          n.scl_lo = 1'b0;
          n.sda_lo = 1'b0;
          n.st = ict_pkg::S_HOLD;
        end
        else if (qtick)
        begin
          case (q.ph)
            2'h0:
            begin
              if (q.bitcnt < ict_pkg::ACK_SLOT)
                n.sda_lo = tx & ~q.data[7];
              else
                n.sda_lo = ~tx & q.aa;
              n.ph = 2'h1;
            end
            2'h1:
            begin
              n.scl_lo = 1'b0;
              if (scl.lvl) // Waits out a slave stretching the clock
                n.ph = 2'h2;
            end
            2'h2:
            begin
              n.ph = 2'h3;
              if (q.bitcnt < ict_pkg::ACK_SLOT)
                n.data = {q.data[6:0], sda.lvl};
              else
                n.ackd = ~sda.lvl;
              if (q.bitcnt < ict_pkg::ACK_SLOT && tx && !q.sda_lo && !sda.lvl)
              begin
                n.stat = sc(ict_pkg::ST_ARB_LOST);
                hw_si = 1'b1;
                n.mst = 1'b0;
                n.st = ict_pkg::S_HOLD;
              end
            end
            default:
            begin
              n.scl_lo = 1'b1;
              n.ph = 2'h0;
              if (q.bitcnt < ict_pkg::ACK_SLOT)
                n.bitcnt = q.bitcnt + 4'h1;
              else
              begin
                n.bitcnt = 4'h0;
                n.sda_lo = 1'b0;
                n.moved = 1'b1;
                n.addr_ph = 1'b0;
                hw_si = 1'b1;
                n.st = ict_pkg::S_HOLD;
                if (q.addr_ph)
                begin
                  n.rd = q.data[0];
                  if (q.data[0])
                    n.stat = q.ackd ? sc(ict_pkg::ST_AR_ACK) : sc(ict_pkg::ST_AR_NACK);
                  else
                    n.stat = q.ackd ? sc(ict_pkg::ST_AW_ACK) : sc(ict_pkg::ST_AW_NACK);
                end
                else if (!q.rd)
                  n.stat = q.ackd ? sc(ict_pkg::ST_TX_ACK) : sc(ict_pkg::ST_TX_NACK);
                else
                  n.stat = q.sda_lo ? sc(ict_pkg::ST_RX_ACK) : sc(ict_pkg::ST_RX_NACK);
              end
            end
          endcase
        end
      end
      ict_pkg::S_MSTOP:
      begin
        if (qtick)
        begin
          case (q.ph)
            2'h0:
            begin
              n.sda_lo = 1'b1;
              n.ph = 2'h1;
            end
            2'h1:
            begin
              n.scl_lo = 1'b0;
              if (scl.lvl)
                n.ph = 2'h2;
            end
            2'h2:
            begin
              n.sda_lo = 1'b0;
              n.ph = 2'h3;
            end
            default:
            begin
              // A start request still set restarts from idle once the bus frees
              n.mst = 1'b0;
              n.stat = sc(ict_pkg::ST_IDLE);
              n.st = ict_pkg::S_IDLE;
            end
          endcase
        end
      end
      ict_pkg::S_SBIT:
      begin
        // Slave follows the master's edges only; the divider plays no part
        if (start_det || stop_det)
        begin
          n.sda_lo = 1'b0;
          n.bitcnt = 4'h0;
          n.addr_ph = 1'b1;
          n.addressed = 1'b0;
          if (q.addressed)
          begin
            n.stat = sc(ict_pkg::ST_SSTOP);
            hw_si = 1'b1;
          end
          if (stop_det)
            n.st = q.addressed ? ict_pkg::S_HOLD : ict_pkg::S_IDLE;
        end
        else if (scl.rise)
        begin
          if (q.bitcnt < ict_pkg::ACK_SLOT)
            n.data = {q.data[6:0], sda.lvl};
          else
            n.ackd = ~sda.lvl;
        end
        else if (scl.fall)
        begin
          if (q.bitcnt < ict_pkg::BIT_LAST)
          begin
            n.bitcnt = q.bitcnt + 4'h1;
            n.sda_lo = q.addressed & q.rd & ~q.addr_ph & ~q.data[7];
          end
          else if (q.bitcnt == ict_pkg::BIT_LAST)
          begin
            n.bitcnt = ict_pkg::ACK_SLOT;
            if (q.addr_ph)
            begin
              if (q.data[7:1] == q.own && q.aa)
              begin
                n.addressed = 1'b1;
                n.rd = q.data[0];
                n.sda_lo = 1'b1;
              end
              else
              begin
                n.sda_lo = 1'b0;
                n.st = ict_pkg::S_IDLE;
              end
            end
            else
              n.sda_lo = ~q.rd & q.aa;
          end
          else
          begin
            n.bitcnt = 4'h0;
            n.sda_lo = 1'b0;
            n.scl_lo = 1'b1;
            n.addr_ph = 1'b0;
            hw_si = 1'b1;
            n.st = ict_pkg::S_HOLD;
            if (q.addr_ph)
              n.stat = q.rd ? sc(ict_pkg::ST_SR_ADDR) : sc(ict_pkg::ST_SW_ADDR);
            else if (q.rd)
            begin
              if (!q.ackd)
                n.stat = sc(ict_pkg::ST_STX_NACK);
              else
                n.stat = q.aa ? sc(ict_pkg::ST_STX_ACK) : sc(ict_pkg::ST_STX_LAST);
              n.addressed = q.ackd & q.aa;
            end
            else
            begin
              n.stat = q.sda_lo ? sc(ict_pkg::ST_SRX_ACK) : sc(ict_pkg::ST_SRX_NACK);
              n.addressed = q.sda_lo;
            end
          end
        end
      end
      ict_pkg::S_HOLD:
      begin
        // Clock stays low here until software clears the service flag; bus error, lost arbitration and slave STOP leave it released
        if (q.stat == sc(ict_pkg::ST_BUS_ERR))
        begin
          if (q.stop_request)
          begin
            n.stop_request = 1'b0;
            n.stat = sc(ict_pkg::ST_IDLE);
            n.st = ict_pkg::S_IDLE;
          end
        end
        else if (!q.si)
        begin
          n.ph = 2'h0;
          n.bitcnt = 4'h0;
          if (q.mst && q.stop_request)
            n.st = ict_pkg::S_MSTOP;
          else if (q.mst && q.start_request && q.moved)
            n.st = ict_pkg::S_MSTART;
          else if (q.mst)
            n.st = ict_pkg::S_MBIT;
          else if (q.addressed)
          begin
            n.st = ict_pkg::S_SBIT;
            n.scl_lo = 1'b0;
            n.sda_lo = q.rd & ~q.data[7];
          end
          else
          begin
            n.stat = sc(ict_pkg::ST_IDLE);
            n.st = ict_pkg::S_IDLE;
          end
        end
      end
      default: n.st = ict_pkg::S_IDLE;
    endcase

    if (!q.en)
    begin
      n.st = ict_pkg::S_IDLE;
      n.stat = sc(ict_pkg::ST_IDLE);
      n.scl_lo = 1'b0;
      n.sda_lo = 1'b0;
      n.mst = 1'b0;
      n.addressed = 1'b0;
    end

    // Hardware set wins over a software clear in the same cycle
    n.si = hw_si | (q.si & ~(wr & (idx == ict_pkg::IDX_CTRL) & ~wd[ict_pkg::CTRL_SI]));
    if (n.stat == sc(ict_pkg::ST_IDLE))
      n.si = 1'b0;
    n.tof = tmo_ovf | (q.tof & ~(wr & (idx == ict_pkg::IDX_TOC) & ~wd[ict_pkg::TOC_FLAG]));
    // Data register only shifts in the bit engines, never while the flag is up
    if (q.si && !wr)
      n.data = q.data;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
      q <= ict_pkg::CORE_RST;
    else if (CE_IN)
      q <= n;
  end

  ////////////////////////////////////////////////////////////////////////
  // Open-drain pins: only ever pull low
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE_OUT = q.scl_lo;
  assign SDA_OE_OUT = q.sda_lo;
  assign WB_ACK_OUT = q.ack;
  assign WB_DAT_OUT = {24'h00_0000, q.rdat};
endmodule

/* File: ict_ctrl_chk.sv */
// Port-level assertions for the I2C controller
`timescale 1ns/1ns
module ict_ctrl_chk #(
  parameter int ADR_W = 12
) (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [ADR_W-1:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire logic SCL_OUT,
  input wire logic SCL_OE_OUT,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT
);
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] idx, rate_q;
  logic rd_a, wr_a, sta_q;
  assign idx = WB_ADR_IN[9:2];
  assign rd_a = WB_ACK_OUT && WB_STB_IN && !WB_WE_IN && WB_ADR_IN[11:10] == 2'h0;
  assign wr_a = WB_ACK_OUT && WB_STB_IN && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN[11:10] == 2'h0;
  // Shadows follow software writes only
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      rate_q <= ict_pkg::RST_RATE;
      sta_q <= 1'b0;
    end
    else if (wr_a && idx == ict_pkg::IDX_RATE)
      rate_q <= WB_DAT_IN[7:0];
    else if (wr_a && idx == ict_pkg::IDX_CTRL)
      sta_q <= WB_DAT_IN[ict_pkg::CTRL_STA];
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence req_s;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  endsequence
  sequence rd_s(logic [7:0] i);
    rd_a && idx == i;
  endsequence
  ack_after_req_a:
    assert property (req_s |=> WB_ACK_OUT)
    else $error("ack missing one cycle after request");
  ack_one_cycle_a:
    assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  stat_format_a:
    assert property (rd_s(ict_pkg::IDX_STATE) |->
      WB_DAT_OUT[2:0] == 3'h0 && WB_DAT_OUT[31:8] == 24'h0)
    else $error("status read has nonzero low or upper bits");
  rate_value_a:
    assert property (rd_s(ict_pkg::IDX_RATE) |-> WB_DAT_OUT[7:0] == rate_q)
    else $error("divider read differs from last write");
  start_kept_a:
    assert property (rd_s(ict_pkg::IDX_CTRL) |-> WB_DAT_OUT[ict_pkg::CTRL_STA] == sta_q)
    else $error("start request changed by hardware");
  unmapped_zero_a:
    assert property (rd_a && (idx < ict_pkg::IDX_DATA || idx > ict_pkg::IDX_OWN) |->
      WB_DAT_OUT == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a:
    assert property ($fell(RST_IN) |-> !WB_ACK_OUT && !SCL_OE_OUT && !SDA_OE_OUT)
    else $error("outputs active after reset");
  open_drain_a:
    assert property (SCL_OE_OUT || SDA_OE_OUT |-> !SCL_OUT && !SDA_OUT)
    else $error("pin driven high");
  read_hold_a:
    assert property (!WB_STB_IN ##1 !WB_STB_IN |-> $stable(WB_DAT_OUT))
    else $error("read data moved without request");
endmodule

/* File: ict_slave_bfm.sv */
// Behavioural write-only slave on the far side of the bus
`timescale 1ns/1ns
module ict_slave_bfm #(
  parameter logic [6:0] ADDR = 7'h3a
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe_out,
  output logic sda_oe_out
);
  logic scl_q;
  logic sda_q;
  logic first_q;
  logic sel_q;
  logic [3:0] cnt_q;
  logic [3:0] hold_q;
  logic [7:0] sh_q;
  // Slow mode stretches each low phase
  assign scl_oe_out = hold_q != 4'h0;
  always_ff @(posedge clk_in)
  begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (rst_in)
    begin
      cnt_q <= 4'h0;
      hold_q <= 4'h0;
      first_q <= 1'b0;
      sel_q <= 1'b0;
      sh_q <= 8'h00;
      sda_oe_out <= 1'b0;
    end
    else if (scl_in && scl_q && sda_q != sda_in)
    begin
      cnt_q <= 4'h0;
      first_q <= !sda_in;
      sda_oe_out <= 1'b0;
    end
    else if (scl_in && !scl_q && cnt_q < 4'h8)
    begin
      sh_q <= {sh_q[6:0], sda_in};
      cnt_q <= cnt_q + 4'h1;
    end
    else if (!scl_in && scl_q)
    begin
      hold_q <= slow_in ? 4'h9 : 4'h0;
      if (cnt_q == 4'h8)
      begin
        sel_q <= first_q ? sh_q == {ADDR, 1'b0} : sel_q;
        sda_oe_out <= first_q ? sh_q == {ADDR, 1'b0} : sel_q;
        first_q <= 1'b0;
        cnt_q <= 4'h9;
      end
      else if (cnt_q == 4'h9)
      begin
        sda_oe_out <= 1'b0;
        cnt_q <= 4'h0;
      end
    end
    else if (hold_q != 4'h0)
      hold_q <= hold_q - 4'h1;
  end
endmodule

/* File: tb_top.sv */
// Self-checking bench: registers, master transfers, time-out
`timescale 1ns/1ns
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("ERROR at %0t: got %h expected %h", $time, (a), (b)); \
    end \
  end
module tb_top;
  localparam int ADR_W = 12;
  localparam logic [6:0] SLV = 7'h3a;
  localparam logic [7:0] CT = ict_pkg::IDX_CTRL, TO = ict_pkg::IDX_TOC, ST = ict_pkg::IDX_STATE,
    DT = ict_pkg::IDX_DATA, RT = ict_pkg::IDX_RATE;
  logic clk, rst, ce, cyc, stb, we, slow, ack, scl_oe, sda_oe, scl_o, sda_o, m_scl, m_sda;
  logic [ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dout, seed;
  logic [7:0] rate, v;
  wire scl_w;
  wire sda_w;
  int err_total, total_checks, per;
  time t0;
  // Pull-ups: released lines read high
  assign scl_w = ~(scl_oe | m_scl);
  assign sda_w = ~(sda_oe | m_sda);
  ict_ctrl #(.ADR_W(ADR_W)) dut (.MCLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(dout), .WB_ACK_OUT(ack), .SCL_IN(scl_w), .SCL_OUT(scl_o),
    .SCL_OE_OUT(scl_oe), .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe));
  ict_slave_bfm #(.ADDR(SLV)) slv (.clk_in(clk), .rst_in(rst), .slow_in(slow),
    .scl_in(scl_w), .sda_in(sda_w), .scl_oe_out(m_scl), .sda_oe_out(m_sda));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int period(input logic [7:0] r);
    return 4 * (r + 1);
  endfunction
  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d,
    output logic [31:0] q);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'h0, i, 2'h0};
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    `CHK(ack, 1'b1)
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    logic [31:0] q;
    wb(1'b0, i, 8'h00, q);
    d = q[7:0];
  endtask
  // Bounded poll; a miss shows in the next check
  task automatic poll(input logic [7:0] i, input int b, input logic x);
    logic [7:0] q;
    int n = 0;
    do
    begin
      rd(i, q);
      n++;
    end
    while (q[b] !== x && n < 2000);
  endtask
  task automatic stat(output logic [7:0] d);
    poll(CT, ict_pkg::CTRL_SI, 1'b1);
    rd(ST, d);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    results();
  end
  initial
  begin
    logic [7:0] ri [5];
    logic [7:0] re [5];
    ri = '{ST, RT, TO, CT, 8'h10};
    re = '{ict_pkg::ST_IDLE, ict_pkg::RST_RATE, 8'h00, 8'h00, 8'h00};
    {rst, cyc, stb, we, slow, adr, wdat} = '0;
    {rst, ce} = 2'h3;
    sel = 4'h1;
    err_total = 0;
    total_checks = 0;
    seed = 32'hda66_8025;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      rd(ri[k], v);
      `CHK(v, re[k])
    end
    seed = lfsr(seed);
    rate = 8'h02 + {6'h00, seed[1:0]};
    wr(RT, rate);
    rd(RT, v);
    `CHK(v, rate)
    wr(CT, 8'h44);
    wr(CT, 8'h64);
    stat(v);
    `CHK(v, ict_pkg::ST_START)
    // Flag pending: clock held low; a frozen enable stalls the time-out
    wr(TO, 8'h04);
    ce <= 1'b0;
    repeat (256) @(posedge clk);
    ce <= 1'b1;
    repeat (16384 - 64) @(posedge clk);
    rd(TO, v);
    `CHK(v, 8'h04)
    `CHK(scl_w, 1'b0)
    repeat (128) @(posedge clk);
    rd(TO, v);
    `CHK(v, 8'h05)
    wr(TO, 8'h00);
    wr(TO, 8'h06);
    repeat (65536 - 2048) @(posedge clk);
    rd(TO, v);
    `CHK(v, 8'h06)
    repeat (4096) @(posedge clk);
    rd(TO, v);
    `CHK(v, 8'h07)
    wr(TO, 8'h00);
    wr(DT, {SLV, 1'b0});
    wr(CT, 8'h44);
    @(posedge scl_w);
    t0 = $time;
    @(posedge scl_w);
    per = int'(($time - t0) / 20);
    `CHK(per >= period(rate) && per <= period(rate) + 6, 1'b1)
    stat(v);
    `CHK(v, ict_pkg::ST_AW_ACK)
    seed = lfsr(seed);
    slow <= 1'b1;
    wr(DT, seed[7:0]);
    wr(CT, 8'h44);
    stat(v);
    `CHK(v, ict_pkg::ST_TX_ACK)
    rd(DT, v);
    `CHK(v, seed[7:0])
    slow <= 1'b0;
    wr(CT, 8'h64);
    stat(v);
    `CHK(v, ict_pkg::ST_RSTART)
    wr(DT, {SLV ^ 7'h01, 1'b0});
    wr(CT, 8'h44);
    stat(v);
    `CHK(v, ict_pkg::ST_AW_NACK)
    wr(CT, 8'h74);
    stat(v);
    `CHK(v, ict_pkg::ST_START)
    rd(CT, v);
    `CHK(v[ict_pkg::CTRL_STO], 1'b0)
    wr(CT, 8'h54);
    poll(CT, ict_pkg::CTRL_STO, 1'b0);
    rd(ST, v);
    `CHK(v, ict_pkg::ST_IDLE)
    rd(CT, v);
    `CHK(v[ict_pkg::CTRL_SI], 1'b0)
    `CHK({scl_w, sda_w}, 2'h3)
    results();
  end
endmodule
bind ict_ctrl ict_ctrl_chk #(.ADR_W(ADR_W)) chk (.MCLK_IN, .RST_IN, .WB_CYC_IN, .WB_STB_IN,
  .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT, .SCL_OUT,
  .SCL_OE_OUT, .SDA_OUT, .SDA_OE_OUT);
